// ### rtl/gpe_port.sv
`timescale 1ns/1ns
module gpe_port (
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [19:0]         pin_in,
   input  wire logic [19:0]         xtal_pin_mask,
   output logic      [19:0]         pin_out,
   output logic      [19:0]         pin_oe,
   output logic      [19:0]         pullup_en,
   output logic                     sysctl_event
);

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   logic                rst_meta_reg;
   logic                rst_sync_n;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_n   <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_n   <= rst_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   gpe_pkg::gpe_state_t st_reg;
   gpe_pkg::gpe_state_t st_next;
   logic                setup_c;
   logic                access_c;
   logic                wr_c;
   logic                rd_c;
   logic                mapped_c;
   logic [19:0]         rise_c;
   logic [19:0]         fall_c;
   logic [19:0]         ev_c;
   logic [19:0]         clr_c;

   assign setup_c  = psel && !penable;
   assign access_c = psel && penable && st_reg.pready;
   assign wr_c     = access_c && pwrite;
   assign rd_c     = access_c && !pwrite;

   always_comb begin
      mapped_c = 1'b1;
      case (paddr)
         gpe_pkg::OFS_LEVEL,  gpe_pkg::OFS_DIR,  gpe_pkg::OFS_OUT,
         gpe_pkg::OFS_FIRST,  gpe_pkg::OFS_PULL, gpe_pkg::OFS_IEN,
         gpe_pkg::OFS_EDGE,   gpe_pkg::OFS_STATUS,
         gpe_pkg::OFS_BYTE,   gpe_pkg::OFS_LANE: mapped_c = 1'b1;
         default: mapped_c = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // edge detection
   // ---------------------------------------------------------------
   // output pins always report rising edges so the status stays
   // meaningful for them; the edge select only shapes inputs
   genvar g;
   generate
      for (g = 0; g < gpe_pkg::PIN_N; g++) begin : g_edge
         assign rise_c[g] = st_reg.sync2[g] && !st_reg.sync3[g];
         assign fall_c[g] = !st_reg.sync2[g] && st_reg.sync3[g];
         assign ev_c[g]   = (st_reg.dir[g] || st_reg.edge_rise[g])
                            ? rise_c[g] : fall_c[g];
      end
   endgenerate

   // only bits that were actually reported are cleared, so an event
   // arriving between setup and access is kept
   assign clr_c = (rd_c && paddr == gpe_pkg::OFS_STATUS)
                  ? st_reg.prdata[19:0] : 20'h00000;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_next         = st_reg;
      st_next.sync1   = pin_in;
      st_next.sync2   = st_reg.sync1;
      st_next.sync3   = st_reg.sync2;
      st_next.status  = (st_reg.status & ~clr_c) | ev_c;
      st_next.pull_out  = st_reg.pull & ~xtal_pin_mask;
      st_next.event_out = |(st_reg.status & st_reg.ien
                            & ~st_reg.dir);
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
      case (st_reg.phase)
         gpe_pkg::GPE_IDLE: begin
            if (setup_c) begin
               st_next.phase   = gpe_pkg::GPE_ACK;
               st_next.pready  = 1'b1;
               st_next.pslverr = !mapped_c;
               st_next.prdata  = 32'h00000000;
               case (paddr)
                  gpe_pkg::OFS_LEVEL:
                     st_next.prdata[19:0] = st_reg.sync2;
                  gpe_pkg::OFS_DIR:
                     st_next.prdata[19:0] = st_reg.dir;
                  gpe_pkg::OFS_OUT:
                     st_next.prdata[19:0] = st_reg.out;
                  gpe_pkg::OFS_FIRST:
                     st_next.prdata[19:0] = st_reg.first_mask;
                  gpe_pkg::OFS_PULL:
                     st_next.prdata[19:0] = st_reg.pull;
                  gpe_pkg::OFS_IEN:
                     st_next.prdata[19:0] = st_reg.ien;
                  gpe_pkg::OFS_EDGE:
                     st_next.prdata[19:0] = st_reg.edge_rise;
                  gpe_pkg::OFS_STATUS:
                     st_next.prdata[19:0] = st_reg.status;
                  gpe_pkg::OFS_BYTE:
                     st_next.prdata[7:0] = st_reg.lane
                        ? st_reg.sync2[15:8] : st_reg.sync2[7:0];
                  gpe_pkg::OFS_LANE:
                     st_next.prdata[0] = st_reg.lane;
                  default: st_next.prdata = 32'h00000000;
               endcase
            end
         end
         gpe_pkg::GPE_ACK: begin
            st_next.phase = gpe_pkg::GPE_IDLE;
            if (wr_c) begin
               case (paddr)
                  gpe_pkg::OFS_DIR:   st_next.dir = pwdata[19:0];
                  gpe_pkg::OFS_OUT:   st_next.out = pwdata[19:0];
                  gpe_pkg::OFS_FIRST: st_next.first_mask = pwdata[19:0];
                  gpe_pkg::OFS_PULL:
                     st_next.pull = (st_reg.pull | st_reg.first_mask)
                                    & ~pwdata[19:0];
                  gpe_pkg::OFS_IEN:
                     st_next.ien = (st_reg.ien | st_reg.first_mask)
                                   & ~pwdata[19:0];
                  gpe_pkg::OFS_EDGE:
                     st_next.edge_rise = (st_reg.edge_rise
                                          & ~pwdata[19:0])
                                         | st_reg.first_mask;
                  gpe_pkg::OFS_BYTE: begin
                     if (st_reg.lane)
                        st_next.out[15:8] = pwdata[7:0];
                     else
                        st_next.out[7:0] = pwdata[7:0];
                  end
                  gpe_pkg::OFS_LANE:  st_next.lane = pwdata[0];
                  default: st_next.lane = st_reg.lane;
               endcase
            end
         end
         default: st_next.phase = gpe_pkg::GPE_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // settings live in this always-on domain, so they hold across sleep
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st_reg            <= '0;
         st_reg.phase      <= gpe_pkg::GPE_IDLE;
         st_reg.dir        <= gpe_pkg::RST_DIR;
         st_reg.out        <= gpe_pkg::RST_OUT;
         st_reg.pull       <= gpe_pkg::RST_PULL;
         st_reg.pull_out   <= gpe_pkg::RST_PULL;
         st_reg.ien        <= gpe_pkg::RST_IEN;
         st_reg.edge_rise  <= gpe_pkg::RST_EDGE;
         // pins idle high through their pull-ups, so the edge history
         // starts high; a zero here would fake a rising edge at start
         st_reg.sync1      <= gpe_pkg::RST_PULL;
         st_reg.sync2      <= gpe_pkg::RST_PULL;
         st_reg.sync3      <= gpe_pkg::RST_PULL;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata       = st_reg.prdata;
   assign pready       = st_reg.pready;
   assign pslverr      = st_reg.pslverr;
   assign pin_out      = st_reg.out;
   assign pin_oe       = st_reg.dir;
   assign pullup_en    = st_reg.pull_out;
   assign sysctl_event = st_reg.event_out;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_sync_n);

   sequence s_wr(logic [7:0] a);
      wr_c && paddr == a;
   endsequence

   property p_unused_zero;
      pready |-> prdata[31:20] == 12'h000;
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unused bitmap bits not zero");

   property p_dir_hold;
      !(wr_c && paddr == gpe_pkg::OFS_DIR) |=> $stable(pin_oe);
   endproperty
   a_dir_hold: assert property (p_dir_hold)
      else $error("direction changed without a write");

   property p_level;
      setup_c && paddr == gpe_pkg::OFS_LEVEL
      |=> prdata[19:0] == $past(st_reg.sync2);
   endproperty
   a_level: assert property (p_level)
      else $error("level read mismatch");

   property p_pull;
      s_wr(gpe_pkg::OFS_PULL) |=> st_reg.pull ==
         (($past(st_reg.pull) | $past(st_reg.first_mask))
          & ~$past(pwdata[19:0]));
   endproperty
   a_pull: assert property (p_pull)
      else $error("pull-up update wrong");

   property p_xtal;
      1'b1 |=> pullup_en == $past(st_reg.pull & ~xtal_pin_mask);
   endproperty
   a_xtal: assert property (p_xtal)
      else $error("pull-up output wrong");

   property p_ien;
      s_wr(gpe_pkg::OFS_IEN) |=> st_reg.ien ==
         (($past(st_reg.ien) | $past(st_reg.first_mask))
          & ~$past(pwdata[19:0]));
   endproperty
   a_ien: assert property (p_ien)
      else $error("enable update wrong");

   property p_edge;
      s_wr(gpe_pkg::OFS_EDGE) |=> st_reg.edge_rise ==
         (($past(st_reg.edge_rise) & ~$past(pwdata[19:0]))
          | $past(st_reg.first_mask));
   endproperty
   a_edge: assert property (p_edge)
      else $error("edge update wrong");

   property p_latch;
      ev_c != 20'h00000 |=> (st_reg.status & $past(ev_c)) == $past(ev_c);
   endproperty
   a_latch: assert property (p_latch)
      else $error("event not latched");

   property p_clear;
      rd_c && paddr == gpe_pkg::OFS_STATUS |=>
         (st_reg.status & $past(prdata[19:0]) & ~$past(ev_c)) == 20'h0;
   endproperty
   a_clear: assert property (p_clear)
      else $error("status not cleared by read");

   property p_event;
      1'b1 |=> sysctl_event ==
         $past(|(st_reg.status & st_reg.ien & ~st_reg.dir));
   endproperty
   a_event: assert property (p_event)
      else $error("system event wrong");

   sequence s_setup(logic [7:0] a);
      setup_c && st_reg.phase == gpe_pkg::GPE_IDLE && paddr == a;
   endsequence

   property p_byte_wr;
      s_wr(gpe_pkg::OFS_BYTE) |=> $past(pwdata[7:0]) ==
         ($past(st_reg.lane) ? pin_out[15:8] : pin_out[7:0]);
   endproperty
   a_byte_wr: assert property (p_byte_wr)
      else $error("byte write landed on wrong pins");

   property p_byte_rd;
      s_setup(gpe_pkg::OFS_BYTE) |=> prdata == {24'h000000,
         ($past(st_reg.lane) ? $past(st_reg.sync2[15:8])
                             : $past(st_reg.sync2[7:0]))};
   endproperty
   a_byte_rd: assert property (p_byte_rd)
      else $error("byte read returned wrong levels");

   property p_status_rd;
      s_setup(gpe_pkg::OFS_STATUS) |=>
         prdata[19:0] == $past(st_reg.status);
   endproperty
   a_status_rd: assert property (p_status_rd)
      else $error("status read did not return pending events");

   property p_ien_hold;
      !(wr_c && paddr == gpe_pkg::OFS_IEN) |=> $stable(st_reg.ien);
   endproperty
   a_ien_hold: assert property (p_ien_hold)
      else $error("event enable changed without a write");

   property p_edge_hold;
      !(wr_c && paddr == gpe_pkg::OFS_EDGE) |=> $stable(st_reg.edge_rise);
   endproperty
   a_edge_hold: assert property (p_edge_hold)
      else $error("edge select changed without a write");

   property p_rise_edge;
      (rise_c & (st_reg.dir | st_reg.edge_rise)) != 20'h00000 |=>
         (st_reg.status & $past(rise_c & (st_reg.dir | st_reg.edge_rise)))
         == $past(rise_c & (st_reg.dir | st_reg.edge_rise));
   endproperty
   a_rise_edge: assert property (p_rise_edge)
      else $error("synced rising edge not latched");

   property p_fall_edge;
      (fall_c & ~st_reg.dir & ~st_reg.edge_rise) != 20'h00000 |=>
         (st_reg.status & $past(fall_c & ~st_reg.dir & ~st_reg.edge_rise))
         == $past(fall_c & ~st_reg.dir & ~st_reg.edge_rise);
   endproperty
   a_fall_edge: assert property (p_fall_edge)
      else $error("synced falling edge not latched");

endmodule : gpe_port

// ### rtl/gpe_pkg.sv
package gpe_pkg;

   localparam int          PIN_N        = 20;
   localparam int          ADDR_W       = 8;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0]  OFS_LEVEL    = 8'h00;
   localparam logic [7:0]  OFS_DIR      = 8'h04;
   localparam logic [7:0]  OFS_OUT      = 8'h08;
   localparam logic [7:0]  OFS_FIRST    = 8'h0c;
   localparam logic [7:0]  OFS_PULL     = 8'h10;
   localparam logic [7:0]  OFS_IEN      = 8'h14;
   localparam logic [7:0]  OFS_EDGE     = 8'h18;
   localparam logic [7:0]  OFS_STATUS   = 8'h1c;
   localparam logic [7:0]  OFS_BYTE     = 8'h20;
   localparam logic [7:0]  OFS_LANE     = 8'h24;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [19:0] RST_DIR      = 20'h00000;
   localparam logic [19:0] RST_OUT      = 20'h00000;
   localparam logic [19:0] RST_PULL     = 20'hfffff;
   localparam logic [19:0] RST_IEN      = 20'h00000;
   localparam logic [19:0] RST_EDGE     = 20'hfffff;

   typedef enum logic [1:0] {
      GPE_IDLE = 2'b01,
      GPE_ACK  = 2'b10
   } gpe_phase_t;

   typedef struct packed {
      gpe_phase_t  phase;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic [19:0] dir;
      logic [19:0] out;
      logic [19:0] pull;
      logic [19:0] ien;
      logic [19:0] edge_rise;
      logic [19:0] status;
      logic [19:0] first_mask;
      logic        lane;
      logic [19:0] sync1;
      logic [19:0] sync2;
      logic [19:0] sync3;
      logic [19:0] pull_out;
      logic        event_out;
   } gpe_state_t;

   typedef struct packed {
      logic [19:0] level;
      logic [19:0] oe;
      logic [19:0] pull_en;
   } gpe_pins_t;

endpackage : gpe_pkg

// ### test/gpe_pin_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// circuitry on the far side of the pins
// ---------------------------------------------------------------
module gpe_pin_model (
   input  wire logic        sys_clk,
   input  wire logic [19:0] pin_out,
   input  wire logic [19:0] pin_oe,
   input  wire logic [19:0] pullup_en,
   input  wire logic [19:0] ext_drv,
   input  wire logic [19:0] ext_val,
   output logic      [19:0] pin_in
);
   logic [19:0] last_reg;

   // a floating pin without pull-up moves every cycle, so no stale
   // level can pass for a good one
   always_ff @(posedge sys_clk) begin
      last_reg <= pin_in;
   end

   assign pin_in = (pin_oe & pin_out)
                 | (~pin_oe & ext_drv & ext_val)
                 | (~pin_oe & ~ext_drv & (pullup_en | ~last_reg));
endmodule : gpe_pin_model

// ### test/gpe_port_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
   n_mismatch++; $display("wrong value at %0t: %h, expected %h", \
   $time, a, b); end end
module gpe_port_tb;
   logic        sys_clk, rst_n, psel, penable, pwrite;
   logic        pready, pslverr, sysctl_event, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [19:0] pin_in, pin_out, pin_oe, pullup_en;
   logic [19:0] xtal_pin_mask, ext_drv, ext_val;
   int          n_mismatch, comparisons;

   gpe_port i_gpe_port (.sys_clk, .rst_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in,
      .xtal_pin_mask, .pin_out, .pin_oe, .pullup_en, .sysctl_event);
   gpe_pin_model i_gpe_pin_model (.sys_clk, .pin_out, .pin_oe,
      .pullup_en, .ext_drv, .ext_val, .pin_in);

   // ---------------------------------------------------------------
   // bus tasks
   // ---------------------------------------------------------------
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // no limit of its own: a slave that never answers is caught by
      // the watchdog, which ends the run as a failure
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask : rchk

   // the staging mask is not cleared, so it is rewritten every time
   task automatic upd(input logic [7:0] a, input logic [19:0] m1,
                      input logic [19:0] m2);
      wr(gpe_pkg::OFS_FIRST, {12'h000, m1});
      wr(a, {12'h000, m2});
   endtask : upd

   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : wt

   task automatic give_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict

   // ---------------------------------------------------------------
   // clock, watchdog and tests
   // ---------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   initial begin
      wt(5000);
      n_mismatch++;
      give_verdict();
   end

   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      xtal_pin_mask = 20'h00000;
      ext_drv = 20'h7ffff;
      ext_val = 20'h00000;
      n_mismatch = 0;
      comparisons = 0;
      wt(12);
      rst_n <= 1'b1;
      wt(3);
      `CHK(pin_oe, 20'h00000)
      `CHK(pullup_en, 20'hfffff)
      rchk(gpe_pkg::OFS_DIR, 32'h0);
      $display("test reset done");
      ext_val <= 20'h5a3c9;
      wt(4);
      rchk(gpe_pkg::OFS_LEVEL, 32'h000da3c9);
      wr(gpe_pkg::OFS_DIR, 32'h000f0);
      wr(gpe_pkg::OFS_OUT, 32'h000a0);
      wt(4);
      rchk(gpe_pkg::OFS_LEVEL, 32'h000da3a9);
      $display("test level done");
      xtal_pin_mask <= 20'h00001;
      upd(gpe_pkg::OFS_PULL, 20'h00003, 20'h0000f);
      wt(2);
      `CHK(pullup_en, 20'hffff0)
      upd(gpe_pkg::OFS_PULL, 20'h00007, 20'h00004);
      wt(2);
      `CHK(pullup_en, 20'hffff2)
      rchk(gpe_pkg::OFS_PULL, 32'h000ffff3);
      xtal_pin_mask <= 20'h00000;
      wt(2);
      `CHK(pullup_en, 20'hffff3)
      $display("test pull done");
      for (int l = 0; l < 2; l++) begin
         wr(gpe_pkg::OFS_DIR, 32'hff << (8 * l));
         wr(gpe_pkg::OFS_LANE, 32'(l));
         wr(gpe_pkg::OFS_BYTE, l ? 32'hc3 : 32'h5a);
         wt(2);
         `CHK(pin_out, l ? 20'h0c35a : 20'h0005a)
      end
      rchk(gpe_pkg::OFS_OUT, 32'h0000c35a);
      wr(gpe_pkg::OFS_DIR, 32'h0);
      ext_val <= 20'h0b7e4;
      for (int l = 0; l < 2; l++) begin
         wr(gpe_pkg::OFS_LANE, 32'(l));
         wt(3);
         rchk(gpe_pkg::OFS_BYTE, l ? 32'hb7 : 32'he4);
      end
      xfer(1'b0, 8'h40, 32'h0);
      `CHK(err, 1'b1)
      `CHK(rd, 32'h0)
      $display("test byte done");
      wr(gpe_pkg::OFS_DIR, 32'h4);
      ext_val <= 20'h00002;
      upd(gpe_pkg::OFS_EDGE, 20'h00001, 20'h00003);
      rchk(gpe_pkg::OFS_EDGE, 32'h000ffffd);
      wt(6);
      xfer(1'b0, gpe_pkg::OFS_STATUS, 32'h0);
      ext_val <= 20'h00001;
      wr(gpe_pkg::OFS_OUT, 32'h4);
      wt(6);
      `CHK(sysctl_event, 1'b0)
      rchk(gpe_pkg::OFS_STATUS, 32'h7);
      rchk(gpe_pkg::OFS_STATUS, 32'h0);
      upd(gpe_pkg::OFS_IEN, 20'h00007, 20'h00002);
      rchk(gpe_pkg::OFS_IEN, 32'h00000005);
      wr(gpe_pkg::OFS_OUT, 32'h0);
      wr(gpe_pkg::OFS_OUT, 32'h4);
      ext_val <= 20'h00000;
      wt(6);
      `CHK(sysctl_event, 1'b0)
      ext_val <= 20'h00001;
      wt(6);
      `CHK(sysctl_event, 1'b1)
      rchk(gpe_pkg::OFS_STATUS, 32'h5);
      wt(2);
      `CHK(sysctl_event, 1'b0)
      $display("test status done");
      give_verdict();
   end
endmodule : gpe_port_tb
